// ---- include/sbc_consts.svh ----
// constants of the stack, branch and control executor
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
`define SBC_OP_EXIT 8'hC9
`define SBC_OP_JVPP 8'hE9
`define SBC_OP_SWAP 8'hE3
`define SBC_OP_LDSK 8'hF9
`define SBC_OP_IN 8'hDB
`define SBC_OP_OUT 8'hD3
`define SBC_OP_IEN 8'hFB
`define SBC_OP_IMSK 8'hF3
`define SBC_OP_STOP 8'h76
`define SBC_ST_CALL_T 5'h11
`define SBC_ST_CALL_N 5'h0B
`define SBC_ST_EXIT 5'h0A
`define SBC_ST_RETC_T 5'h0B
`define SBC_ST_RETC_N 5'h05
`define SBC_ST_RST 5'h0B
`define SBC_ST_PUSH 5'h0B
`define SBC_ST_POP 5'h0A
`define SBC_ST_SWAP 5'h12
`define SBC_ST_ONE5 5'h05
`define SBC_ST_IO 5'h0A
`define SBC_ST_FOUR 5'h04
`define SBC_ST_STOP 5'h07
`define SBC_FB_S 7
`define SBC_FB_Z 6
`define SBC_FB_P 2
`define SBC_FB_C 0
`define SBC_FLAG_MASK 8'hD5
`define SBC_FLAG_FIXED 8'h02
`define SBC_IDX_H 3'h4
`define SBC_IDX_L 3'h5
`define SBC_IDX_A 3'h6
`define SBC_RA_STATUS 12'h000
`define SBC_RA_CTRL 12'h004
`define SBC_RA_PCSP 12'h008
`define SBC_RA_AF 12'h00C
`define SBC_RA_BC 12'h010
`define SBC_RA_DE 12'h014
`define SBC_RA_HL 12'h018
`endif

// ---- include/sbc_pkg.sv ----
// types of the stack, branch and control executor
package sbc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_HALT = 3'b100
    } sbc_state_e;
    typedef enum logic [13:0] {
        C_CALLC = 14'h0001, C_RETC = 14'h0002, C_RST = 14'h0004, C_JVPP = 14'h0008,
        C_PUSH = 14'h0010, C_POP = 14'h0020, C_SWAP = 14'h0040, C_LDSK = 14'h0080,
        C_IN = 14'h0100, C_OUT = 14'h0200, C_IEN = 14'h0400, C_IMSK = 14'h0800,
        C_STOP = 14'h1000, C_IDLE = 14'h2000
    } sbc_cls_e;
endpackage : sbc_pkg

// ---- hdl/sbc_core.sv ----
// stack, branch, port i/o and machine control executor with apb status port
// What this block does
// - conditional call pushes and jumps when condition holds, else skips; 11/17 states
// - return pops pc low from stack pointer, high from next, adds 2; 10 states
// - conditional return does full return only when condition holds; 5/11 states
// - restart pushes next address, drops stack pointer by 2, jumps to 8*vector
// - jump via pointer pair copies H and L into pc; 5 states
// - this group leaves flags alone except status word pop
// - push pair writes high one below stack top, low two below, pointer drops 2
// - status word push stores accumulator then fixed-layout flag byte; 11 states
// - pop pair loads low from stack top, high from next byte, pointer rises 2
// - status word pop restores flags from stack top, accumulator from next byte
// - stack top swap exchanges L with top byte, H with next byte; 18 states
// - load stack copies 16-bit H and L into stack pointer; 5 states
// - port input loads the port byte into accumulator; 10 states
// - port output drives accumulator onto data bus; 10 states
// - interrupt enable acts only after the following instruction; 4 states
// - interrupt mask acts at once; 4 states
// - halt stops execution, registers kept; 7 states
// - idle op changes nothing; 4 states
// - condition field picks nz, z, nc, c, po, pe, p, m
//
// Decided for this implementation: the APB slave port and the address map.
`include "sbc_consts.svh"
module sbc_core #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic op_valid,
    input wire logic [7:0] op_code,
    input wire logic [15:0] op_arg,
    output logic op_ready,
    output logic op_done,
    input wire logic intr,
    output logic int_ack,
    output logic halted,
    output logic [15:0] bus_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic io_rd,
    output logic io_wr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import sbc_pkg::*;

    function automatic logic cond_ok(input logic [2:0] cc, input logic [7:0] f);
        logic v;
        v = 1'b0;
        case (cc[2:1])
            2'b00: v = f[`SBC_FB_Z];
            2'b01: v = f[`SBC_FB_C];
            2'b10: v = f[`SBC_FB_P];
            default: v = f[`SBC_FB_S];
        endcase
        cond_ok = (v == cc[0]);
    endfunction : cond_ok

    function automatic sbc_cls_e op_class(input logic [7:0] op);
        if (op == `SBC_OP_EXIT) op_class = C_RETC;
        else if (op == `SBC_OP_JVPP) op_class = C_JVPP;
        else if (op == `SBC_OP_SWAP) op_class = C_SWAP;
        else if (op == `SBC_OP_LDSK) op_class = C_LDSK;
        else if (op == `SBC_OP_IN) op_class = C_IN;
        else if (op == `SBC_OP_OUT) op_class = C_OUT;
        else if (op == `SBC_OP_IEN) op_class = C_IEN;
        else if (op == `SBC_OP_IMSK) op_class = C_IMSK;
        else if (op == `SBC_OP_STOP) op_class = C_STOP;
        else if (op[7:6] == 2'b11 && op[2:0] == 3'b100) op_class = C_CALLC;
        else if (op[7:6] == 2'b11 && op[2:0] == 3'b000) op_class = C_RETC;
        else if (op[7:6] == 2'b11 && op[2:0] == 3'b111) op_class = C_RST;
        else if (op[7:6] == 2'b11 && op[3:0] == 4'h5) op_class = C_PUSH;
        else if (op[7:6] == 2'b11 && op[3:0] == 4'h1) op_class = C_POP;
        else op_class = C_IDLE;
    endfunction : op_class

    // pair 3 maps onto accumulator (high) and flag byte (index 7)
    function automatic logic [2:0] pair_idx(input logic [1:0] pr, input logic lo);
        pair_idx = {pr, lo};
    endfunction : pair_idx

    function automatic logic apb_hit(input logic [ADDR_W-1:0] a);
        apb_hit = (a == `SBC_RA_STATUS) || (a == `SBC_RA_CTRL) || (a == `SBC_RA_PCSP) ||
                  (a == `SBC_RA_AF) || (a == `SBC_RA_BC) || (a == `SBC_RA_DE) || (a == `SBC_RA_HL);
    endfunction : apb_hit

    sbc_state_e state_q;
    sbc_cls_e cls_q;
    sbc_cls_e cls_in;
    logic [7:0] regs_q [0:6];
    logic [7:0] flags_q;
    logic [15:0] stkp_q;
    logic [15:0] pc_q;
    logic [15:0] tmp_q;
    logic [7:0] op_q;
    logic [15:0] arg_q;
    logic taken_q;
    logic [2:0] nacc_q;
    logic [4:0] total_q;
    logic [4:0] st_q;
    logic [2:0] ai_q;
    logic [1:0] ph_q;
    logic inte_q;
    logic ien_pend_q;
    logic run_q;
    logic [7:0] din_s1_q;
    logic [7:0] din_s2_q;
    logic intr_s1_q;
    logic intr_s2_q;
    logic taken_in;
    logic [2:0] nacc_in;
    logic [4:0] total_in;
    logic [15:0] len_in;
    logic [15:0] acc_addr;
    logic acc_wr;
    logic acc_io;
    logic [7:0] acc_wdata;
    logic [7:0] hi_b;
    logic [7:0] lo_b;
    logic accept;
    logic int_take;
    logic last;
    logic acc_busy;
    logic cap;
    logic [31:0] rd_val;

    // pins are asynchronous to clk
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
            intr_s1_q <= 1'b0;
            intr_s2_q <= 1'b0;
        end else begin
            din_s1_q <= data_in;
            din_s2_q <= din_s1_q;
            intr_s1_q <= intr;
            intr_s2_q <= intr_s1_q;
        end
    end

    assign int_take = intr_s2_q && inte_q && (state_q == ST_IDLE || state_q == ST_HALT);
    assign int_ack = int_take;
    assign op_ready = (state_q == ST_IDLE) && run_q && !int_take;
    assign accept = op_valid && op_ready;
    assign last = (state_q == ST_EXEC) && (st_q == total_q - 5'h01);
    assign op_done = last;
    assign halted = (state_q == ST_HALT);
    assign acc_busy = (state_q == ST_EXEC) && (ai_q < nacc_q);
    assign cap = acc_busy && (ph_q == 2'h3) && !acc_wr;

    always_comb begin
        cls_in = op_class(op_code);
        taken_in = 1'b0;
        nacc_in = 3'h0;
        total_in = `SBC_ST_FOUR;
        len_in = 16'h0001;
        case (cls_in)
            C_CALLC: begin
                taken_in = cond_ok(op_code[5:3], flags_q);
                nacc_in = taken_in ? 3'h2 : 3'h0;
                total_in = taken_in ? `SBC_ST_CALL_T : `SBC_ST_CALL_N;
                len_in = 16'h0003;
            end
            C_RETC: begin
                taken_in = (op_code == `SBC_OP_EXIT) || cond_ok(op_code[5:3], flags_q);
                nacc_in = taken_in ? 3'h2 : 3'h0;
                if (op_code == `SBC_OP_EXIT) total_in = `SBC_ST_EXIT;
                else total_in = taken_in ? `SBC_ST_RETC_T : `SBC_ST_RETC_N;
            end
            C_RST: begin
                nacc_in = 3'h2;
                total_in = `SBC_ST_RST;
            end
            C_PUSH: begin
                nacc_in = 3'h2;
                total_in = `SBC_ST_PUSH;
            end
            C_POP: begin
                nacc_in = 3'h2;
                total_in = `SBC_ST_POP;
            end
            C_SWAP: begin
                nacc_in = 3'h4;
                total_in = `SBC_ST_SWAP;
            end
            C_JVPP, C_LDSK: total_in = `SBC_ST_ONE5;
            C_IN, C_OUT: begin
                nacc_in = 3'h1;
                total_in = `SBC_ST_IO;
                len_in = 16'h0002;
            end
            C_STOP: total_in = `SBC_ST_STOP;
            default: total_in = `SBC_ST_FOUR;
        endcase
    end

    // byte pair of the current write: next address, register pair or status word
    always_comb begin
        hi_b = pc_q[15:8];
        lo_b = pc_q[7:0];
        if (cls_q == C_PUSH) begin
            hi_b = regs_q[pair_idx(op_q[5:4], 1'b0)];
            lo_b = (op_q[5:4] == 2'b11) ? flags_q : regs_q[pair_idx(op_q[5:4], 1'b1)];
        end
    end

    // 16-bit arithmetic wraps on its own, so stack pairs stay consecutive
    always_comb begin
        acc_addr = stkp_q;
        acc_wr = 1'b0;
        acc_io = 1'b0;
        acc_wdata = 8'h00;
        case (cls_q)
            C_CALLC, C_RST, C_PUSH: begin
                acc_wr = 1'b1;
                acc_addr = (ai_q == 3'h0) ? stkp_q - 16'h0001 : stkp_q - 16'h0002;
                acc_wdata = (ai_q == 3'h0) ? hi_b : lo_b;
            end
            C_RETC, C_POP: acc_addr = (ai_q == 3'h0) ? stkp_q : stkp_q + 16'h0001;
            C_SWAP: begin
                acc_addr = ai_q[0] ? stkp_q + 16'h0001 : stkp_q;
                acc_wr = ai_q[1];
                acc_wdata = ai_q[0] ? regs_q[`SBC_IDX_H] : regs_q[`SBC_IDX_L];
            end
            C_IN: begin
                acc_io = 1'b1;
                acc_addr = {arg_q[7:0], arg_q[7:0]};
            end
            C_OUT: begin
                acc_io = 1'b1;
                acc_wr = 1'b1;
                acc_addr = {arg_q[7:0], arg_q[7:0]};
                acc_wdata = regs_q[`SBC_IDX_A];
            end
            default: acc_addr = stkp_q;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (accept) state_q <= ST_EXEC;
                ST_EXEC: if (last) state_q <= (cls_q == C_STOP) ? ST_HALT : ST_IDLE;
                ST_HALT: if (int_take) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cls_q <= C_IDLE;
            op_q <= 8'h00;
            arg_q <= 16'h0000;
            taken_q <= 1'b0;
            nacc_q <= 3'h0;
            total_q <= `SBC_ST_FOUR;
        end else if (accept) begin
            cls_q <= cls_in;
            op_q <= op_code;
            arg_q <= op_arg;
            taken_q <= taken_in;
            nacc_q <= nacc_in;
            total_q <= total_in;
        end
    end

    // each byte access: address out, two strobe cycles, then capture through the synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= 5'h00;
            ai_q <= 3'h0;
            ph_q <= 2'h0;
        end else if (accept) begin
            st_q <= 5'h00;
            ai_q <= 3'h0;
            ph_q <= 2'h0;
        end else if (state_q == ST_EXEC) begin
            st_q <= st_q + 5'h01;
            if (acc_busy) begin
                ph_q <= ph_q + 2'h1;
                if (ph_q == 2'h3) ai_q <= ai_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_addr <= 16'h0000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            io_rd <= 1'b0;
            io_wr <= 1'b0;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else if (acc_busy && ph_q == 2'h0) begin
            bus_addr <= acc_addr;
            mem_rd <= !acc_io && !acc_wr;
            mem_wr <= !acc_io && acc_wr;
            io_rd <= acc_io && !acc_wr;
            io_wr <= acc_io && acc_wr;
            data_out <= acc_wdata;
            data_oe <= acc_wr;
        end else if (acc_busy && ph_q == 2'h2) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            io_rd <= 1'b0;
            io_wr <= 1'b0;
            data_oe <= 1'b0;
        end
    end

    // architectural state; flags are written only by a status word pop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 7; i++) regs_q[i] <= 8'h00;
            flags_q <= `SBC_FLAG_FIXED;
            stkp_q <= 16'h0000;
            pc_q <= 16'h0000;
            tmp_q <= 16'h0000;
            inte_q <= 1'b0;
            ien_pend_q <= 1'b0;
        end else begin
            if (accept) pc_q <= pc_q + len_in;
            if (int_take) inte_q <= 1'b0;
            if (cap) begin
                case (cls_q)
                    C_RETC, C_SWAP: begin
                        if (ai_q[0]) tmp_q[15:8] <= din_s2_q;
                        else tmp_q[7:0] <= din_s2_q;
                    end
                    C_POP: begin
                        if (op_q[5:4] == 2'b11 && ai_q == 3'h0)
                            flags_q <= (din_s2_q & `SBC_FLAG_MASK) | `SBC_FLAG_FIXED;
                        else
                            regs_q[pair_idx(op_q[5:4], !ai_q[0])] <= din_s2_q;
                    end
                    C_IN: regs_q[`SBC_IDX_A] <= din_s2_q;
                    default: tmp_q <= tmp_q;
                endcase
            end
            if (last) begin
                if (ien_pend_q && cls_q != C_IEN) begin
                    inte_q <= 1'b1;
                    ien_pend_q <= 1'b0;
                end
                case (cls_q)
                    C_CALLC: if (taken_q) begin
                        stkp_q <= stkp_q - 16'h0002;
                        pc_q <= arg_q;
                    end
                    C_RETC: if (taken_q) begin
                        stkp_q <= stkp_q + 16'h0002;
                        pc_q <= tmp_q;
                    end
                    C_RST: begin
                        stkp_q <= stkp_q - 16'h0002;
                        pc_q <= {10'h000, op_q[5:3], 3'h0};
                    end
                    C_JVPP: pc_q <= {regs_q[`SBC_IDX_H], regs_q[`SBC_IDX_L]};
                    C_PUSH: stkp_q <= stkp_q - 16'h0002;
                    C_POP: stkp_q <= stkp_q + 16'h0002;
                    C_SWAP: begin
                        regs_q[`SBC_IDX_H] <= tmp_q[15:8];
                        regs_q[`SBC_IDX_L] <= tmp_q[7:0];
                    end
                    C_LDSK: stkp_q <= {regs_q[`SBC_IDX_H], regs_q[`SBC_IDX_L]};
                    C_IEN: ien_pend_q <= 1'b1;
                    C_IMSK: begin
                        inte_q <= 1'b0;
                        ien_pend_q <= 1'b0;
                    end
                    default: tmp_q <= tmp_q;
                endcase
            end
        end
    end

    // apb slave: zero wait states, read data latched in the setup cycle
    assign pready = 1'b1;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (paddr == `SBC_RA_STATUS) rd_val = {28'h000_0000, halted, ien_pend_q, inte_q, run_q};
        else if (paddr == `SBC_RA_CTRL) rd_val = {31'h0000_0000, run_q};
        else if (paddr == `SBC_RA_PCSP) rd_val = {stkp_q, pc_q};
        else if (paddr == `SBC_RA_AF) rd_val = {16'h0000, regs_q[`SBC_IDX_A], flags_q};
        else if (paddr == `SBC_RA_BC) rd_val = {16'h0000, regs_q[3'h0], regs_q[3'h1]};
        else if (paddr == `SBC_RA_DE) rd_val = {16'h0000, regs_q[3'h2], regs_q[3'h3]};
        else if (paddr == `SBC_RA_HL) rd_val = {16'h0000, regs_q[`SBC_IDX_H], regs_q[`SBC_IDX_L]};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= !apb_hit(paddr);
        end
    end

    // run gate stalls instruction intake without disturbing a running one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) run_q <= 1'b1;
        else if (psel && penable && pwrite && paddr == `SBC_RA_CTRL) run_q <= pwdata[0];
    end

    sequence s_take(sbc_cls_e c);
        accept && cls_in == c;
    endsequence

    AST_COND_CALL_SKIP: assert property (@(posedge clk) disable iff (!nrst)
        s_take(C_CALLC) ##0 !taken_in |-> ##11 op_done && pc_q == $past(pc_q, 11) + 16'h0003)
        else $error("skipped call timing or pc wrong");
    // ten quiet cycles split so that no repetition count exceeds eight
    AST_EXIT_TIME: assert property (@(posedge clk) disable iff (!nrst)
        accept && op_code == `SBC_OP_EXIT |-> !op_done [*8] ##1 !op_done [*2] ##1 op_done)
        else $error("return not done in 10 cycles");
    AST_SWAP_TIME: assert property (@(posedge clk) disable iff (!nrst)
        s_take(C_SWAP) |-> ##18 op_done)
        else $error("swap not done in 18 cycles");
    AST_PUSH_STKP: assert property (@(posedge clk) disable iff (!nrst)
        s_take(C_PUSH) |-> ##12 stkp_q == $past(stkp_q, 12) - 16'h0002)
        else $error("push did not drop stack pointer by 2");
    AST_FLAGS_KEPT: assert property (@(posedge clk) disable iff (!nrst)
        flags_q != $past(flags_q) |-> $past(cap) && cls_q == C_POP && op_q[5:4] == 2'b11)
        else $error("flags changed outside status word pop");
    AST_IMSK_NOW: assert property (@(posedge clk) disable iff (!nrst)
        last && cls_q == C_IMSK |=> !inte_q)
        else $error("mask op did not disable at once");
    AST_IEN_LATE: assert property (@(posedge clk) disable iff (!nrst)
        last && cls_q == C_IEN |=> !inte_q && ien_pend_q)
        else $error("enable op acted too early");
    AST_HALT_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        halted && !int_take |=> halted && $stable(pc_q) && $stable(stkp_q))
        else $error("halt left or state changed without interrupt");
    AST_RST_TARGET: assert property (@(posedge clk) disable iff (!nrst)
        s_take(C_RST) |-> ##12 pc_q == {10'h000, $past(op_code[5:3], 12), 3'h0})
        else $error("restart target wrong");
    AST_WRITE_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
        (mem_wr || io_wr) |-> data_oe && !mem_rd && !io_rd)
        else $error("write strobe without data drive");
endmodule : sbc_core

// ---- tb/sbc_mem_model.sv ----
// memory and port devices on the far side of the data bus
module sbc_mem_model (
    input wire logic clk,
    input wire logic [15:0] bus_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    logic [7:0] port_q = 8'h00;
    logic [7:0] out_q = 8'h00;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end
    // an idle bus shows the inverse of the last byte, so a late capture is seen
    always_comb begin
        if (mem_rd) begin
            data_in = mem[bus_addr];
        end else if (io_rd) begin
            data_in = bus_addr[7:0] ^ 8'ha5;
        end else begin
            data_in = ~last_q;
        end
    end
    always @(posedge clk) begin
        if (mem_rd | io_rd) begin
            last_q <= data_in;
        end
        if (mem_wr && data_oe) begin
            mem[bus_addr] <= data_out;
        end
        if (io_wr && data_oe) begin
            port_q <= bus_addr[7:0];
            out_q <= data_out;
        end
    end
endmodule : sbc_mem_model

// ---- tb/stack_branch_control_ops_tb.sv ----
// self-checking bench for the stack, branch and control executor
module stack_branch_control_ops_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic op_valid = 1'b0;
    logic [7:0] op_code = 8'h00;
    logic [15:0] op_arg = 16'h0000;
    logic intr = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic op_ready, op_done, int_ack, halted, mem_rd, mem_wr, io_rd, io_wr, data_oe, pready, pslverr, err;
    logic [15:0] bus_addr, pc_e, stkp_e, w;
    logic [7:0] data_in, data_out;
    logic [31:0] prdata, rd;
    logic [15:0] stk [$];
    int bad_count = 0;
    int comparisons = 0;
    int acks = 0;
    int a0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (int_ack === 1'b1) begin
            acks <= acks + 1;
        end
    end
    sbc_core u_sbc_core (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .op_arg(op_arg),
        .op_ready(op_ready), .op_done(op_done), .intr(intr), .int_ack(int_ack), .halted(halted),
        .bus_addr(bus_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .io_rd(io_rd), .io_wr(io_wr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sbc_mem_model u_sbc_mem_model (.clk(clk), .bus_addr(bus_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .io_rd(io_rd), .io_wr(io_wr), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
    function automatic logic [7:0] m(input logic [15:0] a);
        return u_sbc_mem_model.mem[a];
    endfunction : m
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            bad_count++;
            conclude();
        end
    endtask : apb
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic ps;
        rdchk("pcsp", 12'h008, {stkp_e, pc_e});
    endtask : ps
    // counts states from the accept edge to the completion pulse
    task automatic exec(input logic [7:0] op, input logic [15:0] arg, input int n);
        int i;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= op;
        op_arg <= arg;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (op_ready === 1'b1) break;
        end
        if (i == 40) begin
            bad_count++;
            conclude();
        end
        @(posedge clk);
        op_valid <= 1'b0;
        for (i = 1; i < 40; i++) begin
            @(negedge clk);
            if (op_done === 1'b1) break;
        end
        if (i == 40) begin
            bad_count++;
            conclude();
        end
        chk("states", n, i);
    endtask : exec
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdchk("af", 12'h00c, 32'h0000_0002);
        rdchk("ctrl", 12'h004, 32'h0000_0001);
        apb(1'b1, 12'hffc, 32'h0000_0001);
        chk("unmapped", 1, err);
        u_sbc_mem_model.mem[16'hffff] = 8'hee;
        u_sbc_mem_model.mem[16'h0000] = 8'h34;
        u_sbc_mem_model.mem[16'h0001] = 8'h12;
        u_sbc_mem_model.mem[16'h1234] = 8'hff;
        u_sbc_mem_model.mem[16'h1235] = 8'h9a;
        exec(8'hf5, 16'h0000, 11);
        chk("acc at top", 8'h00, m(16'hffff));
        chk("flag byte", 8'h02, m(16'hfffe));
        exec(8'he1, 16'h0000, 10);
        rdchk("pair", 12'h018, 32'h0000_0002);
        exec(8'he1, 16'h0000, 10);
        rdchk("pair", 12'h018, 32'h0000_1234);
        exec(8'hf9, 16'h0000, 5);
        pc_e = 16'h0004;
        stkp_e = 16'h1234;
        ps();
        exec(8'hf1, 16'h0000, 10);
        rdchk("af", 12'h00c, 32'h0000_9ad7);
        u_sbc_mem_model.mem[16'h1234] = 8'h00;
        u_sbc_mem_model.mem[16'h1235] = 8'h00;
        exec(8'hf5, 16'h0000, 11);
        chk("acc", 8'h9a, m(16'h1235));
        chk("flags", 8'hd7, m(16'h1234));
        pc_e = 16'h0006;
        ps();
        for (int c = 0; c < 8; c++) begin
            pc_e = pc_e + 16'h0003;
            w = 16'h4000 + 16'(c * 16);
            exec(8'hc4 | 8'(c << 3), w, c[0] ? 17 : 11);
            if (c[0]) begin
                stk.push_back(pc_e);
                stkp_e = stkp_e - 16'h0002;
                pc_e = w;
            end
            ps();
        end
        for (int c = 0; c < 8; c++) begin
            pc_e = pc_e + 16'h0001;
            if (c[0]) begin
                chk("stacked", {16'h0000, stk[$]}, {16'h0000, m(stkp_e + 16'h0001), m(stkp_e)});
                pc_e = stk.pop_back();
                stkp_e = stkp_e + 16'h0002;
            end
            exec(8'hc0 | 8'(c << 3), 16'h0000, c[0] ? 11 : 5);
            ps();
        end
        for (int n = 0; n < 8; n++) begin
            stk.push_back(pc_e + 16'h0001);
            stkp_e = stkp_e - 16'h0002;
            pc_e = 16'(n * 8);
            exec(8'hc7 | 8'(n << 3), 16'h0000, 11);
            ps();
        end
        pc_e = stk.pop_back();
        stkp_e = stkp_e + 16'h0002;
        exec(8'hc9, 16'h0000, 10);
        ps();
        exec(8'he9, 16'h0000, 5);
        pc_e = 16'h1234;
        ps();
        w = {m(stkp_e + 16'h0001), m(stkp_e)};
        exec(8'he3, 16'h0000, 18);
        rdchk("pair", 12'h018, {16'h0000, w});
        chk("top", 16'h1234, {m(stkp_e + 16'h0001), m(stkp_e)});
        exec(8'he5, 16'h0000, 11);
        chk("pushed", {16'h0000, w}, {16'h0000, m(stkp_e - 16'h0001), m(stkp_e - 16'h0002)});
        stkp_e = stkp_e - 16'h0002;
        pc_e = 16'h1236;
        ps();
        exec(8'hdb, 16'h0047, 10);
        rdchk("af", 12'h00c, 32'h0000_e2d7);
        exec(8'hd3, 16'h0021, 10);
        chk("port", {8'h21, 8'he2}, {u_sbc_mem_model.port_q, u_sbc_mem_model.out_q});
        exec(8'h00, 16'h0000, 4);
        pc_e = 16'h123b;
        ps();
        rdchk("af", 12'h00c, 32'h0000_e2d7);
        @(posedge clk);
        intr <= 1'b1;
        exec(8'hfb, 16'h0000, 4);
        a0 = acks;
        exec(8'h00, 16'h0000, 4);
        chk("early ack", a0, acks);
        repeat (10) @(posedge clk);
        chk("ack", a0 + 1, acks);
        exec(8'hfb, 16'h0000, 4);
        exec(8'hf3, 16'h0000, 4);
        repeat (20) @(posedge clk);
        chk("masked", a0 + 1, acks);
        intr <= 1'b0;
        exec(8'hfb, 16'h0000, 4);
        exec(8'h00, 16'h0000, 4);
        exec(8'h76, 16'h0000, 7);
        repeat (20) @(posedge clk);
        chk("halted", 1, halted);
        rdchk("af", 12'h00c, 32'h0000_e2d7);
        intr <= 1'b1;
        repeat (12) @(posedge clk);
        chk("woken", 0, halted);
        chk("ack", a0 + 2, acks);
        conclude();
    end
endmodule : stack_branch_control_ops_tb
